/* File: include/lae_pkg.sv */
package lae_pkg;

   // Register offsets on the device register port
   localparam logic [7:0] LANE_CTRL_OFS = 8'h13;
   localparam logic [7:0] DS_EQ_OFS = 8'h20;
   localparam logic [7:0] US_EQ_OFS = 8'h21;

   // Reset value shared by every register of the bank
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [3:0] EQ_RESET = 4'h0;
   localparam logic [4:0] LANE_COUNT_RESET = 5'h00;

   // Field positions in the lane and AUX control register
   localparam int unsigned SNOOP_OFF_BIT = 7;
   localparam int unsigned ROUTE_LO_BIT = 4;
   localparam int unsigned LANE_OFF_LO_BIT = 0;

   // Field positions in the equalization registers
   localparam int unsigned EQ_A_LO_BIT = 0;
   localparam int unsigned EQ_B_LO_BIT = 4;
   localparam int unsigned EQ_UP_LO_BIT = 0;

   // Widths
   localparam int unsigned LANES = 4;
   localparam int unsigned EQ_W = 4;
   localparam int unsigned LANE_COUNT_W = 5;
   localparam int unsigned AUX_ADDR_W = 20;

   // Sink address whose write carries the lane count
   localparam logic [19:0] LANE_COUNT_ADDR = 20'h00101;

   // AUX to SBU routing override encodings
   typedef enum logic [1:0]
   {
      ROUTE_AUTO = 2'h0,
      ROUTE_STRAIGHT = 2'h1,
      ROUTE_CROSSED = 2'h2,
      ROUTE_OPEN = 2'h3
   } lae_route_e;

   typedef struct packed
   {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } lae_reg_req_s;

   typedef struct packed
   {
      logic valid;
      logic [19:0] addr;
      logic [7:0] data;
   } lae_aux_wr_s;

   typedef struct packed
   {
      logic p_sbu1;
      logic p_sbu2;
      logic n_sbu1;
      logic n_sbu2;
   } lae_sbu_route_s;

endpackage

/* File: logic/lae_aux_route.sv */
`timescale 1ns/100ps
// AUX to SBU switch decode
module lae_aux_route
(
   input wire logic sys_clk, // 25 MHz clock
   input wire logic rst, // Async reset, active high
   input lae_pkg::lae_route_e override, // Routing override field
   input wire logic mode_select_high, // High mode select bit
   input wire logic orientation_select, // Plug flip select
   output lae_pkg::lae_sbu_route_s route_q // Switch closures
);

   lae_pkg::lae_sbu_route_s route_d;

   always_comb
   begin
      route_d = '0;
      case (override)
         lae_pkg::ROUTE_AUTO:
         begin
            route_d.p_sbu1 = mode_select_high && !orientation_select;
            route_d.n_sbu2 = mode_select_high && !orientation_select;
            route_d.p_sbu2 = mode_select_high && orientation_select;
            route_d.n_sbu1 = mode_select_high && orientation_select;
         end
         lae_pkg::ROUTE_STRAIGHT:
         begin
            route_d.p_sbu1 = 1'b1;
            route_d.n_sbu2 = 1'b1;
         end
         lae_pkg::ROUTE_CROSSED:
         begin
            route_d.p_sbu2 = 1'b1;
            route_d.n_sbu1 = 1'b1;
         end
         lae_pkg::ROUTE_OPEN:
            route_d = '0;
         default:
            route_d = '0;
      endcase
   end

   // Registered so the analog switch never sees decode glitches
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         route_q <= '0;
      else
         route_q <= route_d;
   end

endmodule

/* File: logic/lae_eq_select.sv */
`timescale 1ns/100ps
// One receiver equalization source: strap pins or software value
module lae_eq_select #(
   parameter int unsigned W = 4
)
(
   input wire logic sys_clk, // 25 MHz clock
   input wire logic rst, // Async reset, active high
   input wire logic [1:0] straps, // Strap pin pair
   input wire logic [W-1:0] sw_value, // Value software wrote
   input wire logic sw_source, // High selects software value
   output logic [W-1:0] eq_q // Applied equalization
);

   logic strap_taken_q;
   logic [1:0] strap_q;

   // Straps caught once, at the first edge after reset release
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         strap_taken_q <= 1'b0;
         strap_q <= 2'h0;
      end
      else if (!strap_taken_q)
      begin
         strap_taken_q <= 1'b1;
         strap_q <= straps;
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         eq_q <= lae_pkg::EQ_RESET;
      else if (sw_source)
         eq_q <= sw_value;
      else
         eq_q <= W'(strap_q);
   end

   strap_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
      strap_taken_q |=> $stable(strap_q))
      else $error("strap sample changed after capture");

   strap_source_a: assert property (@(posedge sys_clk) disable iff (rst)
      !sw_source && strap_taken_q |=> eq_q == W'($past(strap_q)))
      else $error("strap equalization not applied");

endmodule

/* File: logic/lae_lane_regs.sv */
`timescale 1ns/100ps
module lae_lane_regs
(
   input wire logic sys_clk, // 25 MHz clock
   input wire logic rst, // Async reset, active high
   input lae_pkg::lae_reg_req_s reg_req, // Register port request
   output logic [7:0] reg_rd_data, // Read data
   output logic reg_rd_valid, // Read data valid pulse
   input lae_pkg::lae_aux_wr_s aux_wr, // Monitored AUX write
   input wire logic eq_software_source, // Equalization from registers
   input wire logic mode_select_high, // High mode select bit
   input wire logic orientation_select, // Plug flip select
   input wire logic [1:0] downstream_eq_straps, // Downstream strap pins
   input wire logic [1:0] upstream_eq_straps, // Upstream strap pins
   output logic [3:0] lane_en, // Per lane enable
   output lae_pkg::lae_sbu_route_s sbu_route, // AUX to SBU closures
   output logic [3:0] downstream_rx_a_eq, // Receiver A equalization
   output logic [3:0] downstream_rx_b_eq, // Receiver B equalization
   output logic [3:0] upstream_rx_eq // Upstream receiver equalization
);

   localparam int unsigned EW = lae_pkg::EQ_W;
   localparam int unsigned LW = lae_pkg::LANE_COUNT_W;

   logic snoop_off_q;
   lae_pkg::lae_route_e route_q;
   logic [lae_pkg::LANES-1:0] lane_off_q;
   logic [EW-1:0] eq_a_sw_q;
   logic [EW-1:0] eq_b_sw_q;
   logic [EW-1:0] eq_up_sw_q;
   logic [LW-1:0] lane_count_q;
   logic mode_hi_prev_q;
   logic [3:0] lane_en_q;
   logic [3:0] lane_en_d;
   logic [7:0] rd_data_q;
   logic rd_valid_q;
   logic [7:0] rd_addr_q;
   logic wr_lane;
   logic wr_ds;
   logic wr_us;
   logic count_hit;

   assign wr_lane = reg_req.wr && (reg_req.addr == lae_pkg::LANE_CTRL_OFS);
   assign wr_ds = reg_req.wr && (reg_req.addr == lae_pkg::DS_EQ_OFS);
   assign wr_us = reg_req.wr && (reg_req.addr == lae_pkg::US_EQ_OFS);
   assign count_hit = aux_wr.valid && !snoop_off_q
      && (aux_wr.addr == lae_pkg::LANE_COUNT_ADDR);

   // Lane and AUX control register
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         snoop_off_q <= 1'b0;
         route_q <= lae_pkg::ROUTE_AUTO;
         lane_off_q <= '0;
      end
      else if (wr_lane)
      begin
         snoop_off_q <= reg_req.wdata[lae_pkg::SNOOP_OFF_BIT];
         route_q <= lae_pkg::lae_route_e'(reg_req.wdata[lae_pkg::ROUTE_LO_BIT +: 2]);
         lane_off_q <= reg_req.wdata[lae_pkg::LANE_OFF_LO_BIT +: lae_pkg::LANES];
      end
   end

   // Software equalization values, kept even while straps drive the receivers
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         eq_a_sw_q <= lae_pkg::EQ_RESET;
         eq_b_sw_q <= lae_pkg::EQ_RESET;
         eq_up_sw_q <= lae_pkg::EQ_RESET;
      end
      else
      begin
         if (wr_ds)
         begin
            eq_a_sw_q <= reg_req.wdata[lae_pkg::EQ_A_LO_BIT +: EW];
            eq_b_sw_q <= reg_req.wdata[lae_pkg::EQ_B_LO_BIT +: EW];
         end
         if (wr_us)
            eq_up_sw_q <= reg_req.wdata[lae_pkg::EQ_UP_LO_BIT +: EW];
      end
   end

   // Lane count taken from monitored AUX traffic
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         lane_count_q <= lae_pkg::LANE_COUNT_RESET;
         mode_hi_prev_q <= 1'b0;
      end
      else
      begin
         mode_hi_prev_q <= mode_select_high;
         if (count_hit)
            lane_count_q <= aux_wr.data[LW-1:0];
         else if (mode_hi_prev_q && !mode_select_high)
            lane_count_q <= lae_pkg::LANE_COUNT_RESET;
      end
   end

   // Per lane enable decision
   generate
      for (genvar i = 0; i < lae_pkg::LANES; i++)
      begin : g_lane
         always_comb
         begin
            if (snoop_off_q)
               lane_en_d[i] = !lane_off_q[i];
            else
               lane_en_d[i] = lane_count_q > LW'(i);
         end
      end
   endgenerate

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         lane_en_q <= '0;
      else
         lane_en_q <= lane_en_d;
   end

   assign lane_en = lane_en_q;

   lae_eq_select #(.W(EW)) u_eq_a
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .straps(downstream_eq_straps),
      .sw_value(eq_a_sw_q),
      .sw_source(eq_software_source),
      .eq_q(downstream_rx_a_eq)
   );

   lae_eq_select #(.W(EW)) u_eq_b
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .straps(downstream_eq_straps),
      .sw_value(eq_b_sw_q),
      .sw_source(eq_software_source),
      .eq_q(downstream_rx_b_eq)
   );

   lae_eq_select #(.W(EW)) u_eq_up
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .straps(upstream_eq_straps),
      .sw_value(eq_up_sw_q),
      .sw_source(eq_software_source),
      .eq_q(upstream_rx_eq)
   );

   lae_aux_route u_route
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .override(route_q),
      .mode_select_high(mode_select_high),
      .orientation_select(orientation_select),
      .route_q(sbu_route)
   );

   // Read path; equalization fields show what the receivers really use, not the stored value
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         rd_data_q <= lae_pkg::REG_RESET;
         rd_valid_q <= 1'b0;
         rd_addr_q <= 8'h00;
      end
      else
      begin
         rd_valid_q <= reg_req.rd;
         rd_addr_q <= reg_req.addr;
         if (reg_req.rd)
         begin
            case (reg_req.addr)
               lae_pkg::LANE_CTRL_OFS:
                  rd_data_q <= {snoop_off_q, 1'b0, route_q, lane_off_q};
               lae_pkg::DS_EQ_OFS:
                  rd_data_q <= {downstream_rx_b_eq, downstream_rx_a_eq};
               lae_pkg::US_EQ_OFS:
                  rd_data_q <= {4'h0, upstream_rx_eq};
               default:
                  rd_data_q <= 8'h00;
            endcase
         end
      end
   end

   assign reg_rd_data = rd_data_q;
   assign reg_rd_valid = rd_valid_q;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   sequence count_write_s;
      aux_wr.valid && !snoop_off_q && aux_wr.addr == lae_pkg::LANE_COUNT_ADDR;
   endsequence

   // Lane check uses the snoop off bit that fed the enable register
   sequence count_applied_s(logic [LW-1:0] cnt);
      ##1 lane_count_q == cnt ##1 ($past(snoop_off_q) || lane_en_q == {(cnt > 5'h03),
         (cnt > 5'h02), (cnt > 5'h01), (cnt > 5'h00)});
   endsequence

   reset_zero_a: assert property (
      $past(rst) |-> (!snoop_off_q && lane_off_q == 4'h0 && route_q == lae_pkg::ROUTE_AUTO
         && eq_a_sw_q == 4'h0 && eq_b_sw_q == 4'h0 && eq_up_sw_q == 4'h0))
      else $error("bank not zero after reset");

   manual_lanes_a: assert property (
      snoop_off_q && $stable(snoop_off_q) |=> lane_en_q == ~$past(lane_off_q))
      else $error("manual lane disable not applied");

   // Compares the enables across the disable write itself
   monitor_lanes_a: assert property (
      !snoop_off_q && $stable(snoop_off_q) && $changed(lane_off_q)
         && $stable(lane_count_q) |=> $stable(lane_en_q))
      else $error("lane disable bit acted while monitoring");

   // Count kept in a local; the bus data moves on after one cycle
   property count_capture_p;
      logic [LW-1:0] cnt;
      (count_write_s, cnt = aux_wr.data[LW-1:0]) |-> count_applied_s(cnt);
   endproperty

   count_capture_a: assert property (count_capture_p)
      else $error("lane count write not applied");

   route_auto_a: assert property (
      route_q == lae_pkg::ROUTE_AUTO && mode_select_high && !orientation_select
         |=> sbu_route == 4'b1001)
      else $error("auto routing wrong");

   route_flip_a: assert property (
      route_q == lae_pkg::ROUTE_AUTO && mode_select_high && orientation_select
         |=> sbu_route == 4'b0110)
      else $error("flipped auto routing wrong");

   route_idle_a: assert property (
      route_q == lae_pkg::ROUTE_AUTO && !mode_select_high |=> sbu_route == 4'b0000)
      else $error("auto routing closed without mode");

   route_straight_a: assert property (
      route_q == lae_pkg::ROUTE_STRAIGHT |=> sbu_route == 4'b1001)
      else $error("straight routing wrong");

   route_crossed_a: assert property (
      route_q == lae_pkg::ROUTE_CROSSED |=> sbu_route == 4'b0110)
      else $error("crossed routing wrong");

   route_open_a: assert property (
      route_q == lae_pkg::ROUTE_OPEN |=> sbu_route == 4'b0000)
      else $error("open routing wrong");

   software_eq_a: assert property (
      eq_software_source |=> downstream_rx_b_eq == $past(eq_b_sw_q)
         && downstream_rx_a_eq == $past(eq_a_sw_q)
         && upstream_rx_eq == $past(eq_up_sw_q))
      else $error("software equalization not applied");

   reserved_read_a: assert property (
      rd_valid_q && rd_addr_q == lae_pkg::US_EQ_OFS |-> rd_data_q[7:4] == 4'h0)
      else $error("reserved bits read nonzero");

   lane_reserved_a: assert property (
      rd_valid_q && rd_addr_q == lae_pkg::LANE_CTRL_OFS |-> !rd_data_q[6])
      else $error("reserved lane bit read nonzero");

endmodule

/* File: testbench/lae_host_model.sv */
`timescale 1ns/100ps
// Register host and AUX source standing at the far side of the bank
module lae_host_model
(
   input wire logic sys_clk, // System clock
   output lae_pkg::lae_reg_req_s reg_req, // Register request
   input wire logic [7:0] reg_rd_data, // Read data
   input wire logic reg_rd_valid, // Read data valid
   output lae_pkg::lae_aux_wr_s aux_wr // Monitored AUX write
);
   initial
   begin
      reg_req = '0;
      aux_wr = '0;
   end

   // Strobe high for one taking edge, then a quiet cycle before the next
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(negedge sys_clk);
      reg_req.addr = addr;
      reg_req.wdata = data;
      reg_req.wr = 1'b1;
      @(negedge sys_clk);
      reg_req.wr = 1'b0;
      // Idle data never repeats the last byte
      reg_req.wdata = ~data;
   endtask

   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
      int n;
      @(negedge sys_clk);
      reg_req.addr = addr;
      reg_req.rd = 1'b1;
      @(negedge sys_clk);
      reg_req.rd = 1'b0;
      ok = 1'b0;
      data = 8'hxx;
      for (n = 0; n < 4 && !ok; n++)
      begin
         if (reg_rd_valid === 1'b1)
         begin
            ok = 1'b1;
            data = reg_rd_data;
         end
         else
            @(negedge sys_clk);
      end
   endtask

   task automatic aux_write(input logic [19:0] addr, input logic [7:0] data);
      @(negedge sys_clk);
      aux_wr.addr = addr;
      aux_wr.data = data;
      aux_wr.valid = 1'b1;
      @(negedge sys_clk);
      aux_wr.valid = 1'b0;
      aux_wr.addr = ~addr;
      aux_wr.data = ~data;
   endtask
endmodule

/* File: testbench/lane_aux_eq_control_regs_bench.sv */
`timescale 1ns/100ps
module lane_aux_eq_control_regs_bench;
   logic sys_clk;
   logic rst;
   logic eq_src;
   logic msh;
   logic orient;
   logic [1:0] ds_straps;
   logic [1:0] us_straps;
   lae_pkg::lae_reg_req_s reg_req;
   lae_pkg::lae_aux_wr_s aux_wr;
   logic [7:0] reg_rd_data;
   logic reg_rd_valid;
   logic [3:0] lane_en;
   logic [3:0] eq_a;
   logic [3:0] eq_b;
   logic [3:0] eq_up;
   lae_pkg::lae_sbu_route_s sbu_route;
   int num_errors = 0;
   int comparisons = 0;
   // Packed {override, mode high, orientation, expected closures}
   logic [7:0] rtab [6] = '{8'h00, 8'h29, 8'h36, 8'h59, 8'h86, 8'he0};

   lae_lane_regs i_lae_lane_regs
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .reg_req(reg_req),
      .reg_rd_data(reg_rd_data),
      .reg_rd_valid(reg_rd_valid),
      .aux_wr(aux_wr),
      .eq_software_source(eq_src),
      .mode_select_high(msh),
      .orientation_select(orient),
      .downstream_eq_straps(ds_straps),
      .upstream_eq_straps(us_straps),
      .lane_en(lane_en),
      .sbu_route(sbu_route),
      .downstream_rx_a_eq(eq_a),
      .downstream_rx_b_eq(eq_b),
      .upstream_rx_eq(eq_up)
   );

   lae_host_model i_lae_host_model
   (
      .sys_clk(sys_clk),
      .reg_req(reg_req),
      .reg_rd_data(reg_rd_data),
      .reg_rd_valid(reg_rd_valid),
      .aux_wr(aux_wr)
   );

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      comparisons++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
      logic [7:0] d;
      logic ok;
      i_lae_host_model.read_reg(addr, d, ok);
      if (!ok)
      begin
         num_errors++;
         $display("mismatch at %0t: read answer never came", $time);
         final_report();
      end
      check(d, exp, "register read");
   endtask

   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      i_lae_host_model.write_reg(addr, data);
   endtask

   // Outputs trail a write by two edges; two spare cycles of margin
   task automatic settle();
      repeat (3) @(negedge sys_clk);
   endtask

   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   initial
   begin
      rst = 1'b1;
      eq_src = 1'b0;
      msh = 1'b0;
      orient = 1'b0;
      ds_straps = 2'h2;
      us_straps = 2'h1;
      repeat (4) @(negedge sys_clk);
      rst = 1'b0;
      settle();
      check({4'h0, lane_en}, 8'h00, "lanes after reset");
      rd_chk(8'h13, 8'h00);
      rd_chk(8'h20, 8'h22);
      rd_chk(8'h21, 8'h01);
      wr(8'h13, 8'hff);
      rd_chk(8'h13, 8'hbf);
      wr(8'h05, 8'h5a);
      rd_chk(8'h05, 8'h00);
      wr(8'h13, 8'h8a);
      settle();
      check({4'h0, lane_en}, 8'h05, "manual lanes");
      i_lae_host_model.aux_write(20'h00101, 8'h04);
      settle();
      check({4'h0, lane_en}, 8'h05, "monitor off ignores aux");
      wr(8'h13, 8'h0f);
      i_lae_host_model.aux_write(20'h00101, 8'h02);
      settle();
      check({4'h0, lane_en}, 8'h03, "two lanes by count");
      i_lae_host_model.aux_write(20'h00102, 8'h04);
      settle();
      check({4'h0, lane_en}, 8'h03, "other sink address");
      i_lae_host_model.aux_write(20'h00101, 8'h04);
      settle();
      check({4'h0, lane_en}, 8'h0f, "four lanes by count");
      rd_chk(8'h13, 8'h0f);
      wr(8'h13, 8'h05);
      settle();
      check({4'h0, lane_en}, 8'h0f, "disable bits ignored");
      rd_chk(8'h13, 8'h05);
      for (int i = 0; i < 6; i++)
      begin
         @(negedge sys_clk);
         msh = rtab[i][5];
         orient = rtab[i][4];
         wr(8'h13, {2'h2, rtab[i][7:6], 4'h0});
         settle();
         check({4'h0, sbu_route}, {4'h0, rtab[i][3:0]}, "aux routing");
      end
      // Mode bit fell inside the loop, so the captured count is gone
      wr(8'h13, 8'h00);
      settle();
      check({4'h0, lane_en}, 8'h00, "count cleared by mode fall");
      check({4'h0, sbu_route}, 8'h09, "auto routing straight");
      wr(8'h20, 8'h97);
      settle();
      check({4'h0, eq_a}, 8'h02, "strap source a");
      rd_chk(8'h20, 8'h22);
      @(negedge sys_clk);
      eq_src = 1'b1;
      settle();
      check({4'h0, eq_a}, 8'h07, "software eq a");
      check({4'h0, eq_b}, 8'h09, "software eq b");
      rd_chk(8'h20, 8'h97);
      wr(8'h21, 8'hfb);
      settle();
      check({4'h0, eq_up}, 8'h0b, "software eq up");
      rd_chk(8'h21, 8'h0b);
      @(negedge sys_clk);
      eq_src = 1'b0;
      settle();
      check({4'h0, eq_up}, 8'h01, "strap source up");
      check({4'h0, eq_b}, 8'h02, "strap source b");
      // Nonzero state so the second reset has something to clear
      wr(8'h13, 8'hb5);
      @(negedge sys_clk);
      rst = 1'b1;
      @(negedge sys_clk);
      rst = 1'b0;
      settle();
      rd_chk(8'h13, 8'h00);
      check({4'h0, lane_en}, 8'h00, "lanes after second reset");
      check({4'h0, sbu_route}, 8'h09, "routing after second reset");
      @(negedge sys_clk);
      eq_src = 1'b1;
      settle();
      rd_chk(8'h20, 8'h00);
      rd_chk(8'h21, 8'h00);
      final_report();
   end
endmodule
